/* testbench/pdly_partner.sv */
// Purpose : Far-side model: logic source on the input, load on the output
// Assumes : Levels change just after a rising clock edge
// Notes   : Source never glitches by itself; the bench commands every edge

`timescale 1ns/10ps

module pdly_partner (
	input  wire logic clk,
	input  wire logic out_level,
	output logic      in_level
);
	// ==========================================================
	// Source side
	// ==========================================================
	initial in_level = 1'b0;    // Quiet low at power-up

	// Change level now, caller is already on an edge
	task automatic set_in(input logic v);
		in_level <= v;
	endtask

	// Change level at the next rising edge
	task automatic drive(input logic v);
		@(posedge clk);
		in_level <= v;
	endtask

	// ==========================================================
	// Load side
	// ==========================================================
	// Edges until the load sees lvl; capped so a dead output cannot hang
	task automatic wait_out(input logic lvl, input int lim, output int n);
		n = 0;
		while (out_level !== lvl && n < lim) begin
			@(posedge clk);
			n++;
		end
	endtask
endmodule // pdly_partner

/* testbench/testbench.sv */
// Purpose : Self-checking bench for the programmable edge delay
// Assumes : Short tick and start-up parameters keep the run brief
// Notes   : Delays are timed in clock edges with a small sync margin

`timescale 1ns/10ps

module testbench;
	import pdly_pkg::*;

	// ==========================================================
	// Settings and signals
	// ==========================================================
	localparam int DIV   = 2;       // Clock cycles per tick
	localparam int BOOT  = 4;       // Start-up ticks
	localparam int LIMIT = 40000;   // Hang ceiling in cycles
	logic        mclk, rst_n, dual, psel, penable, pwrite, inv;
	logic [3:0]  code;              // ratio_code pin
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, in_level, out_level;
	int          cyc = 0;           // Cycle count since time zero
	int          error_cnt = 0;
	int          samples_checked = 0;
	logic [31:0] d;                 // Scratch read data
	logic        e;                 // Scratch error flag
	logic [3:0]  prev;              // Last accepted code
	logic [3:0]  cl [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hc, 4'hd, 4'he, 4'hf};

	pdly_edge_delay #(.OSC_DIV(DIV), .BOOT_TCKS(BOOT)) u_pdly_edge_delay (
		.MCLK(mclk), .RST_N(rst_n), .IN_LEVEL(in_level), .RATIO_CODE(code),
		.DUAL_EDGE(dual), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .OUT_LEVEL(out_level));

	pdly_partner u_pdly_partner (.clk(mclk), .out_level(out_level), .in_level(in_level));

	// ==========================================================
	// Clock and hang guard
	// ==========================================================
	always #12.5 mclk = ~mclk;

	// Count cycles; a hang counts as a mismatch
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			error_cnt++;
			complete_run();
		end
	end

	// ==========================================================
	// Reporting
	// ==========================================================
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Seen value if inside the window, else the lower bound
	function automatic int near(input int n, input int lo, input int hi);
		return (n >= lo && n <= hi) ? n : lo;
	endfunction

	task automatic complete_run();
		if (error_cnt == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ==========================================================
	// APB master
	// ==========================================================
	// Holds the request until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int w;
		@(posedge mclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		w = 0;
		do begin
			@(posedge mclk);
			w++;
		end while (pready !== 1'b1 && w < 50);
		rd = prdata;
		err = pslverr;
		check("apb answer", w < 50, 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// ==========================================================
	// Scenario helpers
	// ==========================================================
	// Poll the accepted code; only old or new may ever show
	task automatic wait_code(input logic [3:0] c, input logic [3:0] old, input int exp);
		int t0;
		logic bad;
		t0 = cyc;
		bad = 1'b0;
		do begin
			apb(1'b0, ADDR_STAT, 32'h0, d, e);
			if (d[3:0] !== c && d[3:0] !== old)
				bad = 1'b1;
		end while (d[3:0] !== c && cyc - t0 < 3000);
		check("accepted code", d[3:0], c);
		check("intermediate code", bad, 1'b0);
		check("code latency", cyc - t0, near(cyc - t0, exp - 4, exp + 12));
	endtask

	// Settle at the opposite level, then time one edge of level lvl
	task automatic measure(input logic lvl, input int exp, input string what);
		int n;
		u_pdly_partner.drive(!lvl);
		u_pdly_partner.wait_out(!lvl ^ inv, 20000, n);
		repeat (3) @(posedge mclk);
		u_pdly_partner.drive(lvl);
		u_pdly_partner.wait_out(lvl ^ inv, exp + 20, n);
		check(what, n, near(n, exp, exp + 4));
	endtask

	// Pulse shorter than the delay; output must hold
	task automatic glitch(input int hold);
		logic o;
		logic moved;
		o = out_level;
		moved = 1'b0;
		u_pdly_partner.drive(!in_level);
		repeat (hold) @(posedge mclk);
		u_pdly_partner.set_in(!in_level);
		repeat (30) begin
			@(posedge mclk);
			if (out_level !== o)
				moved = 1'b1;
		end
		check("short pulse held", moved, 1'b0);
	endtask

	// Reset, wiggle input during start-up, time release of the output
	task automatic boot(input logic [3:0] c, input logic dl, input logic lvl);
		int n;
		@(posedge mclk);
		rst_n <= 1'b0;
		code  <= c;
		dual  <= dl;
		u_pdly_partner.drive(lvl);
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		n = 0;
		while (out_level !== 1'b1 && n < 1000) begin
			@(posedge mclk);
			n++;
			if (n == 40 || n == 50)
				u_pdly_partner.set_in(n == 40 ? !lvl : lvl);
		end
		check("start-up length", n, near(n, 96 * DIV, 96 * DIV + 12));
	endtask

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial begin
		mclk = 1'b0;
		rst_n = 1'b0;
		code = 4'h0;
		dual = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		inv = 1'b0;
		boot(4'h0, 1'b0, 1'b1);
		// Status and register map
		apb(1'b0, ADDR_STAT, 32'h0, d, e);
		check("running", d[STAT_RDY_BIT], 1'b1);
		check("stat error", e, 1'b0);
		check("single variant", d[STAT_DUAL_BIT], 1'b0);
		apb(1'b0, ADDR_CTRL, 32'h0, d, e);
		check("ctrl reset", d, CTRL_RST);
		apb(1'b0, 12'h008, 32'h0, d, e);
		check("unmapped error", e, 1'b1);
		check("unmapped data", d, 32'h0);
		apb(1'b1, ADDR_STAT, 32'hff, d, e);
		apb(1'b0, ADDR_STAT, 32'h0, d, e);
		check("stat write ignored", d[3:0], 4'h0);
		// Ratios 1 to 512, both polarities, single-edge variant
		prev = 4'h0;
		foreach (cl[i]) begin
			if (cl[i] != prev) begin
				@(posedge mclk);
				code <= cl[i];
				wait_code(cl[i], prev, 16 * ((cl[i] > prev ? cl[i] - prev : prev - cl[i]) + 6) * DIV);
			end
			prev = cl[i];
			measure(!cl[i][3], (8 ** (cl[i][3] ? ~cl[i][2:0] : cl[i][2:0])) * DIV,
				"delayed edge");
			measure(cl[i][3], 0, "passed edge");
			if (cl[i] == 4'h1) begin
				glitch(6);
				measure(1'b1, 8 * DIV, "restarted delay");
			end
		end
		// Software code source
		apb(1'b1, ADDR_CTRL, 32'h12, d, e);
		apb(1'b0, ADDR_CTRL, 32'h0, d, e);
		check("ctrl readback", d, 32'h12);
		wait_code(4'h2, 4'hf, 16 * 19 * DIV);
		// Dual-edge variant, inverted then plain
		inv = 1'b1;
		boot(4'he, 1'b1, 1'b0);
		apb(1'b0, ADDR_STAT, 32'h0, d, e);
		check("dual variant", d[STAT_DUAL_BIT], 1'b1);
		check("stat code", d[3:0], 4'he);
		check("stat output", d[STAT_OUT_BIT], 1'b1);
		check("timer idle", d[STAT_TIME_BIT], 1'b0);
		measure(1'b1, 8 * DIV, "dual rise inverted");
		measure(1'b0, 8 * DIV, "dual fall inverted");
		glitch(5);
		@(posedge mclk);
		code <= 4'h1;
		wait_code(4'h1, 4'he, 16 * 19 * DIV);
		inv = 1'b0;
		// Fall first: a new code leaves the old output level standing until an edge
		measure(1'b0, 8 * DIV, "dual fall plain");
		measure(1'b1, 8 * DIV, "dual rise plain");
		complete_run();
	end
endmodule // testbench

/* verilog/pdly_code_filter.sv */
// Purpose : Stability filter for the ratio_code
// Assumes : tick is one MCLK cycle wide, once per oscillator_period
// Notes   : Settling grows with the code distance being crossed

`timescale 1ns/10ps

module pdly_code_filter
	import pdly_pkg::*;
#(
	parameter int CW = CODE_W,
	parameter int FW = FILT_W
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          tick,
	input  wire logic [CW-1:0] raw_code,
	output logic      [CW-1:0] acc_code,
	output logic               acc_valid
);

	// ==========================================================
	// State
	// ==========================================================
	logic [CW-1:0] cand_q;    // Code under observation
	logic [CW-1:0] acc_q;     // Code in use
	logic          valid_q;   // A code has been accepted
	logic [FW-1:0] stab_q;    // Ticks the candidate held still
	logic [CW-1:0] diff;      // Distance candidate to accepted
	logic [FW-1:0] thresh;    // Ticks needed before acceptance
	logic          settled;   // Nothing left to accept

	// Before the first acceptance the distance counts as zero
	always_comb begin
		if (!valid_q) begin
			diff = '0;
		end else if (cand_q > acc_q) begin
			diff = cand_q - acc_q;
		end else begin
			diff = acc_q - cand_q;
		end
		thresh  = FW'(FILT_MULT * (int'(diff) + FILT_BASE)); // R14
		settled = valid_q && (cand_q == acc_q);
	end

	// ==========================================================
	// Filter
	// ==========================================================
	// Any wobble restarts the wait; the jump goes straight to the
	// final code, so no intermediate code is ever applied
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cand_q  <= '0;
			acc_q   <= '0;
			valid_q <= 1'b0;
			stab_q  <= '0;
		end else if (raw_code != cand_q) begin
			// New value seen: restart stability count
			cand_q <= raw_code; // R13
			stab_q <= '0;
		end else if (tick && !settled) begin
			if (stab_q >= thresh - FW'(1)) begin
				acc_q   <= cand_q; // R15
				valid_q <= 1'b1;
				stab_q  <= '0;
			end else begin
				stab_q <= stab_q + FW'(1);
			end
		end
	end

	assign acc_code  = acc_q;
	assign acc_valid = valid_q;

	// ==========================================================
	// Checks
	// ==========================================================
	accept_wait_a : assert property (@(posedge clk) disable iff (!rst_n) // R14
		$changed(acc_q) |-> $past(stab_q) == $past(thresh) - FW'(1))
		else $error("ratio code accepted before settling time");

	no_midcode_a : assert property (@(posedge clk) disable iff (!rst_n) // R15
		$changed(acc_q) |-> acc_q == $past(cand_q) && acc_q == $past(raw_code))
		else $error("accepted code differs from stable candidate");

endmodule // pdly_code_filter

/* verilog/pdly_edge_delay.sv */
// Purpose : Programmable edge delay and pulse qualifier
// Assumes : IN_LEVEL and RATIO_CODE synchronous to MCLK; DUAL_EDGE static
// Notes   : APB slave with one wait state; PREADY is registered
//
// Overview of operation
// [R1] Codes 0-7 give ratios 1 to 2^21
// [R2] Ratio mirrored about code midpoint
// [R3] Polarity is ratio code MSB
// [R4] Delay equals ratio times oscillator period
// [R5] Single-edge: polarity picks delayed edge
// [R6] Dual-edge: polarity one inverts output
// [R7] Rising edge times, output high if held
// [R8] Early return no change; restart timing
// [R9] Other edge passes straight through
// [R10] Dual-edge delays both edges fully
// [R11] Dual-edge change back restarts timing
// [R12] Dual-edge output pulse never shorter
// [R13] Ratio code sampled continuously after start
// [R14] Code change takes 16*(diff+6) periods
// [R15] Only stable codes accepted, no intermediates
// [R16] Mid-timing change ends between both delays
// [R17] Output low, input ignored during start-up
// [R18] Start-up about 500 periods, ratio-independent
// [R19] Valid code needed before leaving start-up
// [R20] Start-up end copies input to output
// [R21] Falling mode mirrors rising mode
// [R22] Variant select is static configuration

`timescale 1ns/10ps

module pdly_edge_delay
	import pdly_pkg::*;
#(
	parameter int OSC_DIV   = OSC_CYCLES,     // MCLK cycles per tick
	parameter int BOOT_TCKS = STARTUP_TICKS   // start-up length in ticks
) (
	input  wire logic              MCLK,
	input  wire logic              RST_N,
	input  wire logic              IN_LEVEL,
	input  wire logic [CODE_W-1:0] RATIO_CODE,
	input  wire logic              DUAL_EDGE,
	input  wire logic              PSEL,
	input  wire logic              PENABLE,
	input  wire logic              PWRITE,
	input  wire logic [ADDR_W-1:0] PADDR,
	input  wire logic [31:0]       PWDATA,
	output logic      [31:0]       PRDATA,
	output logic                   PREADY,
	output logic                   PSLVERR,
	output logic                   OUT_LEVEL
);

	// ==========================================================
	// Declarations
	// ==========================================================
	pdly_state_t          state_q;       // Start-up or running
	logic [PRESC_W-1:0]   presc_q;       // Oscillator prescaler
	logic                 tick;          // One oscillator_period passed
	logic [BOOT_W-1:0]    boot_q;        // Start-up tick count
	logic                 boot_done;     // Start-up may end now
	logic                 dual_q;        // Latched variant select
	logic                 in_prev_q;     // Last seen input level
	logic                 out_q;         // Output level
	logic                 timing_q;      // Delay in progress
	logic [RATIO_W-1:0]   cnt_q;         // Ticks since timing start
	logic [CODE_W-1:0]    ctrl_code_q;   // Software ratio_code
	logic                 ctrl_src_q;    // Software code selected
	logic [CODE_W-1:0]    code_src;      // Code fed to the filter
	logic [CODE_W-1:0]    ratio_code;    // Accepted code
	logic                 code_ok;       // Filter has a code
	logic                 polarity_bit;  // Ratio code MSB
	logic [2:0]           ratio_exp;     // Ratio step index
	logic [RATIO_W-1:0]   divide_ratio;  // Ticks per delay
	logic                 invert;        // Dual-edge inversion
	logic                 run;           // Edge-delay operation
	logic                 edge_seen;     // Input changed
	logic                 start_evt;     // Edge that starts timing
	logic                 pass_evt;      // Edge that passes at once
	logic                 expire;        // Programmed delay reached
	logic                 apb_acc;       // Access phase, first cycle
	logic                 apb_done;      // Transfer completes now
	logic                 ctrl_hit;      // Address is control
	logic                 stat_hit;      // Address is status
	logic [31:0]          rd_mux;        // Read data selection

	// ==========================================================
	// Ratio decode
	// ==========================================================
	// Upper half counts back down, so the table is mirrored
	always_comb begin
		polarity_bit = ratio_code[CODE_W-1]; // R3
		if (polarity_bit) begin
			ratio_exp = ~ratio_code[2:0]; // R2
		end else begin
			ratio_exp = ratio_code[2:0]; // R1
		end
		divide_ratio = RATIO_W'(1) << (5'(ratio_exp) * 5'(RATIO_STEP)); // R1
		invert       = dual_q & polarity_bit; // R6
	end

	// Pin code unless software takes over the setting
	assign code_src = ctrl_src_q ? ctrl_code_q : RATIO_CODE;

	// ==========================================================
	// Code filter
	// ==========================================================
	pdly_code_filter #(
		.CW (CODE_W),
		.FW (FILT_W)
	) u_filter (
		.clk       (MCLK),
		.rst_n     (RST_N),
		.tick      (tick),
		.raw_code  (code_src),
		.acc_code  (ratio_code),
		.acc_valid (code_ok)
	);

	// ==========================================================
	// Oscillator tick
	// ==========================================================
	assign tick = (presc_q == PRESC_W'(OSC_DIV - 1));

	// Restarted by a timing edge so the delay is whole periods
	// from that edge; the filter sees a slightly stretched tick
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			presc_q <= '0;
		end else if (start_evt || tick) begin
			presc_q <= '0; // R4
		end else begin
			presc_q <= presc_q + PRESC_W'(1);
		end
	end

	// ==========================================================
	// Start-up
	// ==========================================================
	// Count does not look at the ratio; an unsettled code
	// simply keeps the block waiting
	assign boot_done = (state_q == PDLY_BOOT)
		&& (boot_q >= BOOT_W'(BOOT_TCKS)) && code_ok; // R18 R19

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			boot_q <= '0;
		end else if (state_q == PDLY_BOOT && tick && boot_q < BOOT_W'(BOOT_TCKS)) begin
			boot_q <= boot_q + BOOT_W'(1); // R18
		end
	end

	// Variant caught by a clock edge during start-up only
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			dual_q <= 1'b0;
		end else if (state_q == PDLY_BOOT) begin
			dual_q <= DUAL_EDGE; // R22
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			state_q <= PDLY_BOOT;
		end else begin
			case (state_q)
				PDLY_BOOT: begin
					if (boot_done) begin
						state_q <= PDLY_RUN;
					end
				end
				PDLY_RUN: begin
					state_q <= PDLY_RUN;
				end
				default: begin
					state_q <= PDLY_BOOT;
				end
			endcase
		end
	end

	// ==========================================================
	// Edge classification
	// ==========================================================
	// Single-edge: polarity 0 delays rising, 1 delays falling
	always_comb begin
		run       = (state_q == PDLY_RUN);
		edge_seen = run && (IN_LEVEL != in_prev_q);
		start_evt = edge_seen && (dual_q || (IN_LEVEL != polarity_bit)); // R5 R10 R21
		pass_evt  = edge_seen && !dual_q && (IN_LEVEL == polarity_bit); // R9 R21
		// Ratio shrunk to or below the count ends at the next tick, growing one runs on
		expire    = timing_q && tick && (cnt_q >= divide_ratio - RATIO_W'(1)); // R16
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			in_prev_q <= 1'b0;
		end else begin
			in_prev_q <= IN_LEVEL;
		end
	end

	// ==========================================================
	// Delay timer
	// ==========================================================
	// A new start edge always wins over a same-cycle expiry
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			timing_q <= 1'b0;
			cnt_q    <= '0;
		end else if (start_evt) begin
			timing_q <= 1'b1; // R8 R11
			cnt_q    <= '0;
		end else if (pass_evt || expire || !run) begin
			timing_q <= 1'b0;
			cnt_q    <= '0;
		end else if (timing_q && tick) begin
			cnt_q <= cnt_q + RATIO_W'(1); // R4
		end
	end

	// ==========================================================
	// Output
	// ==========================================================
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			out_q <= 1'b0;
		end else if (!run) begin
			if (boot_done) begin
				out_q <= IN_LEVEL ^ invert; // R20
			end else begin
				out_q <= 1'b0; // R17
			end
		end else if (pass_evt) begin
			out_q <= IN_LEVEL; // R9
		end else if (expire && !start_evt) begin
			// Held level reaches the output only now
			out_q <= IN_LEVEL ^ invert; // R7 R10 R12
		end
	end

	assign OUT_LEVEL = out_q;

	// ==========================================================
	// APB slave
	// ==========================================================
	assign apb_acc  = PSEL && PENABLE && !PREADY;
	assign apb_done = PSEL && PENABLE && PREADY;
	assign ctrl_hit = (PADDR == ADDR_CTRL);
	assign stat_hit = (PADDR == ADDR_STAT);

	// Status shows live block state
	always_comb begin
		rd_mux = '0;
		if (ctrl_hit) begin
			rd_mux[CTRL_CODE_LSB +: CODE_W] = ctrl_code_q;
			rd_mux[CTRL_SRC_BIT]            = ctrl_src_q;
		end else if (stat_hit) begin
			rd_mux[STAT_CODE_LSB +: CODE_W] = ratio_code;
			rd_mux[STAT_RDY_BIT]            = run;
			rd_mux[STAT_TIME_BIT]           = timing_q;
			rd_mux[STAT_OUT_BIT]            = out_q;
			rd_mux[STAT_DUAL_BIT]           = dual_q;
		end
	end

	// One wait state keeps PRDATA and PREADY registered
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= '0;
		end else begin
			PREADY <= apb_acc;
			if (apb_acc) begin
				PSLVERR <= !(ctrl_hit || stat_hit);
				PRDATA  <= PWRITE ? 32'h0000_0000 : rd_mux;
			end else begin
				PSLVERR <= 1'b0;
			end
		end
	end

	// Write lands on the completing edge only
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_code_q <= CTRL_RST[CTRL_CODE_LSB +: CODE_W];
			ctrl_src_q  <= CTRL_RST[CTRL_SRC_BIT];
		end else if (apb_done && PWRITE && ctrl_hit) begin
			ctrl_code_q <= PWDATA[CTRL_CODE_LSB +: CODE_W];
			ctrl_src_q  <= PWDATA[CTRL_SRC_BIT];
		end
	end

	// ==========================================================
	// Checks
	// ==========================================================
	sequence boot_leave_s;
		state_q == PDLY_BOOT ##1 state_q == PDLY_RUN;
	endsequence

	ratio_table_a : assert property (@(posedge MCLK) disable iff (!RST_N) // R1
		ratio_code == 4'h3 |-> divide_ratio == 22'h000200)
		else $error("code 3 does not select ratio 512");

	ratio_mirror_a : assert property (@(posedge MCLK) disable iff (!RST_N) // R2
		ratio_code == 4'h8 |-> divide_ratio == 22'h200000)
		else $error("code 8 does not select the largest ratio");

	polarity_msb_a : assert property (@(posedge MCLK) disable iff (!RST_N) // R3
		run && dual_q && ratio_code[3] && expire && !start_evt
		|=> OUT_LEVEL != $past(IN_LEVEL))
		else $error("inverting dual-edge output not inverted");

	boot_low_a : assert property (@(posedge MCLK) disable iff (!RST_N) // R17
		state_q == PDLY_BOOT |-> !OUT_LEVEL)
		else $error("output high during start-up");

	// Input edges during start-up must never arm the timer
	boot_idle_a : assert property (@(posedge MCLK) disable iff (!RST_N) // R17
		!run |=> !timing_q)
		else $error("delay timing during start-up");

	boot_length_a : assert property (@(posedge MCLK) disable iff (!RST_N) // R18
		$rose(run) |-> $past(boot_q) >= BOOT_W'(BOOT_TCKS) && $past(code_ok))
		else $error("start-up ended early");

	boot_copy_a : assert property (@(posedge MCLK) disable iff (!RST_N) // R20
		boot_leave_s |-> OUT_LEVEL == ($past(IN_LEVEL) ^ $past(invert)))
		else $error("start-up end did not copy the input");

	pass_now_a : assert property (@(posedge MCLK) disable iff (!RST_N) // R9
		pass_evt |=> OUT_LEVEL == $past(IN_LEVEL) && !timing_q)
		else $error("undelayed edge not passed at once");

	restart_a : assert property (@(posedge MCLK) disable iff (!RST_N) // R8
		start_evt |=> timing_q && cnt_q == '0 && presc_q == '0)
		else $error("timing not restarted from zero");

	hold_out_a : assert property (@(posedge MCLK) disable iff (!RST_N) // R11
		run && !pass_evt && !expire |=> $stable(OUT_LEVEL))
		else $error("output moved without expiry or pass");

	one_tick_a : assert property (@(posedge MCLK) disable iff (!RST_N) // R4
		start_evt && ratio_code == 4'h0 && OSC_DIV == 2 ##1 !edge_seen [*2]
		|=> OUT_LEVEL == (in_prev_q ^ invert))
		else $error("ratio 1 delay not one period");

endmodule // pdly_edge_delay

/* verilog/pdly_pkg.sv */
// Purpose : Shared constants and types for the programmable edge delay
// Assumes : MCLK at 40 MHz; oscillator_period derived from it
// Notes   : Every offset, field, reset value and count is named here once

package pdly_pkg;

	// ==========================================================
	// Timing
	// ==========================================================
	localparam int MCLK_PERIOD_NS = 25;     // 40 MHz master clock
	localparam int OSC_PERIOD_NS  = 1000;   // oscillator_period, 1 us
	// MCLK cycles per oscillator_period (exact division)
	localparam int OSC_CYCLES     = OSC_PERIOD_NS / MCLK_PERIOD_NS;
	localparam int STARTUP_TICKS  = 500;    // startup_interval in ticks
	localparam int FILT_MULT      = 16;     // code_change_latency factor
	localparam int FILT_BASE      = 6;      // code_change_latency offset

	// ==========================================================
	// Widths
	// ==========================================================
	localparam int CODE_W     = 4;          // ratio_code width
	localparam int RATIO_W    = 22;         // holds divide_ratio up to 2^21
	localparam int RATIO_STEP = 3;          // log2 of ratio step (x8)
	localparam int FILT_W     = 9;          // filter counter, max 336
	localparam int PRESC_W    = 16;         // prescaler width
	localparam int BOOT_W     = 16;         // start-up tick counter width
	localparam int ADDR_W     = 12;         // APB address width

	// ==========================================================
	// Register map
	// ==========================================================
	localparam logic [11:0] ADDR_CTRL     = 12'h000;
	localparam logic [11:0] ADDR_STAT     = 12'h004;
	localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
	localparam int          CTRL_CODE_LSB = 0;   // software ratio_code
	localparam int          CTRL_SRC_BIT  = 4;   // 1: use software code
	localparam int          STAT_CODE_LSB = 0;   // accepted ratio_code
	localparam int          STAT_RDY_BIT  = 4;   // start-up finished
	localparam int          STAT_TIME_BIT = 5;   // delay timing active
	localparam int          STAT_OUT_BIT  = 6;   // output level
	localparam int          STAT_DUAL_BIT = 7;   // dual-edge variant

	// ==========================================================
	// Types
	// ==========================================================
	typedef enum logic {
		PDLY_BOOT,
		PDLY_RUN
	} pdly_state_t;

endpackage
